/* verilog/afh_pkg.sv */
package afh_pkg;
   // word width of the buffer device
   localparam int DATA_W = 9;
   // strobe timing at 10 MHz (period in ns)
   localparam int CLK_PERIOD_NS = 100;
   localparam int STROBE_LOW_NS = 50;    // least strobe low width
   localparam int STROBE_HIGH_NS = 15;   // least strobe high width
   localparam int ACCESS_NS = 50;        // read low to data valid
   localparam int FLAG_NS = 45;          // strobe to flag settle
   localparam int RESET_NS = 65;         // reset low width
   localparam int LOW_CYC =
      (STROBE_LOW_NS + CLK_PERIOD_NS - 1) / CLK_PERIOD_NS;
   localparam int HIGH_CYC =
      (STROBE_HIGH_NS + CLK_PERIOD_NS - 1) / CLK_PERIOD_NS;
   localparam int ACC_CYC =
      (ACCESS_NS + CLK_PERIOD_NS - 1) / CLK_PERIOD_NS;
   localparam int FLAG_CYC =
      (FLAG_NS + CLK_PERIOD_NS - 1) / CLK_PERIOD_NS;
   localparam int RST_CYC =
      (RESET_NS + CLK_PERIOD_NS - 1) / CLK_PERIOD_NS;
   // wait counter width and one-step constant
   localparam int CNT_W = 4;
   localparam logic [CNT_W-1:0] CNT_ONE = 4'h1;
   // word as carried on the user side
   typedef struct packed {
      logic [DATA_W-1:0] data;
   } afh_word_t;
   // strobes driven to the device, all active low
   typedef struct packed {
      logic write_n;
      logic read_n;
      logic reset_n;
      logic retx_n;
      logic oe_n;
   } afh_strobe_t;
   // flags read back from the device, active low
   typedef struct packed {
      logic full_flag_n;
      logic empty_flag_n;
   } afh_flag_t;
endpackage : afh_pkg

/* verilog/afh_skid.sv */
`timescale 1ns/1ns
`default_nettype none
// two-entry buffer: a stall downstream loses no word
module afh_skid #(
   parameter int WIDTH = 9
) (
   input  wire logic             sys_clk,
   input  wire logic             srst,
   input  wire logic [WIDTH-1:0] in_data,
   input  wire logic             in_valid,
   output logic                  in_ready,
   output logic      [WIDTH-1:0] out_data,
   output logic                  out_valid,
   input  wire logic             out_ready
);
   logic [WIDTH-1:0] hold_data, next_hold_data, next_out_data;
   logic             hold_valid, next_hold_valid, next_out_valid;
   logic             push;

   // output stage is a register, so the top sees flop outputs; a word
   // that meets a stall waits in the hold slot
   always_comb begin
      push = in_valid && !hold_valid;
      next_out_data = out_data;
      next_out_valid = out_valid;
      next_hold_data = hold_data;
      next_hold_valid = hold_valid;
      if (!out_valid || out_ready) begin
         // output frees at this edge: the older held word goes first
         if (hold_valid) begin
            next_out_data = hold_data;
            next_out_valid = 1'b1;
            next_hold_valid = 1'b0;
         end else begin
            next_out_valid = push;
            if (push)
               next_out_data = in_data;
         end
      end else if (push) begin
         next_hold_data = in_data;
         next_hold_valid = 1'b1;
      end
   end

   always_ff @(posedge sys_clk) begin
      if (srst) begin
         out_data <= '0;
         out_valid <= 1'b0;
         hold_data <= '0;
         hold_valid <= 1'b0;
      end else begin
         out_data <= next_out_data;
         out_valid <= next_out_valid;
         hold_data <= next_hold_data;
         hold_valid <= next_hold_valid;
      end
   end

   // ready while the hold slot is free; both slots full stalls the source
   assign in_ready = !hold_valid;
endmodule : afh_skid
`default_nettype wire

/* verilog/afh_host.sv */
`timescale 1ns/1ns
`default_nettype none
// Summary of operation
// - writer watches full flag, reader watches empty flag of its buffer
// - reader toggles read strobe to fetch further words
// - writer toggles write strobe only while full flag is high
// - flag pulses may be arbitrarily short; tolerate them
module afh_host
   import afh_pkg::*;
#(
   parameter int DW = DATA_W
) (
   input  wire logic                  sys_clk,
   input  wire logic                  srst,
   input  wire logic                  clear_req,
   input  wire logic                  retx_req,
   input  wire logic [DW-1:0]         wr_data,
   input  wire logic                  wr_valid,
   output logic                       wr_ready,
   output logic      [DW-1:0]         rd_data,
   output logic                       rd_valid,
   input  wire logic                  rd_ready,
   output var afh_pkg::afh_strobe_t   strobe,
   output logic      [DW-1:0]         dev_data_in,
   input  wire logic                  full_flag_n,
   input  wire logic                  empty_flag_n,
   input  wire logic [DW-1:0]         data_out_bus
);
   import afh_pkg::*;

   typedef enum {
      AFH_IDLE,
      AFH_RST,
      AFH_W_LOW,
      AFH_W_HIGH,
      AFH_R_LOW,
      AFH_R_HIGH,
      AFH_RT_LOW,
      AFH_RT_HIGH
   } afh_state_t;

   // sequencer state and its wait counter
   afh_state_t       state, next_state;
   logic [CNT_W-1:0] cnt, next_cnt;
   afh_strobe_t      next_strobe;
   logic [DW-1:0]    next_dev_data_in;
   // read word captured at the end of the access wait
   logic [DW-1:0]    cap, next_cap;
   logic             cap_valid, next_cap_valid;
   // registered write grant; wr_ready is this flop and nothing else
   logic             wr_ready_r, next_wr_ready;
   logic             wr_take;
   // three-stage flag synchronisers; stage 1 read only by stage 2
   afh_flag_t        f1, f2, f3, flag, next_flag;
   logic [DW-1:0]    q1, q2;
   logic             sk_in_ready;

   // counter in its last cycle; also true if it starts at zero
   function automatic logic cnt_done(input logic [CNT_W-1:0] c);
      return c <= CNT_ONE;
   endfunction : cnt_done

   // flag settles only once stages two and three agree, so a short
   // flow-through pulse is ignored or seen, never half-seen
   always_comb begin
      next_flag = flag;
      if (f2.full_flag_n == f3.full_flag_n)
         next_flag.full_flag_n = f3.full_flag_n;
      if (f2.empty_flag_n == f3.empty_flag_n)
         next_flag.empty_flag_n = f3.empty_flag_n;
   end

   // pin stages; the bus copy is only read at the end of a read wait
   always_ff @(posedge sys_clk) begin
      f1 <= {full_flag_n, empty_flag_n};
      f2 <= f1;
      f3 <= f2;
      q1 <= data_out_bus;
      q2 <= q1;
      if (srst)
         flag <= '{full_flag_n: 1'b1, empty_flag_n: 1'b0};
      else
         flag <= next_flag;
   end

   // a word is taken only on an edge that sees valid and the grant
   assign wr_take = wr_valid && wr_ready;

   // strobe sequencer: one write or read cycle at a time
   always_comb begin
      next_state = state;
      next_cnt = cnt;
      next_strobe = strobe;
      next_dev_data_in = dev_data_in;
      next_cap = cap;
      next_cap_valid = 1'b0;
      next_wr_ready = 1'b0;
      if (cnt != '0)
         next_cnt = cnt - CNT_ONE;
      case (state)
         AFH_IDLE: begin
            if (wr_take) begin
               // a grant already given is honoured first, otherwise a
               // clear in the same cycle would drop the taken word
               next_dev_data_in = wr_data;
               next_strobe.write_n = 1'b0;
               next_cnt = CNT_W'(LOW_CYC);
               next_state = AFH_W_LOW;
            end else if (clear_req) begin
               next_strobe.reset_n = 1'b0; // pointers to zero
               next_cnt = CNT_W'(RST_CYC);
               next_state = AFH_RST;
            end else if (retx_req) begin
               next_strobe.retx_n = 1'b0; // read and write held high
               next_cnt = CNT_W'(RST_CYC);
               next_state = AFH_RT_LOW;
            end else if (flag.empty_flag_n && sk_in_ready) begin
               // read only when not empty and room is downstream
               next_strobe.read_n = 1'b0;
               next_strobe.oe_n = 1'b0;
               next_cnt = CNT_W'(ACC_CYC + 2);
               next_state = AFH_R_LOW;
            end else begin
               // grant only with no clear or retransmit waiting
               next_wr_ready = flag.full_flag_n;
            end
         end
         AFH_RST, AFH_RT_LOW: begin
            if (cnt_done(cnt)) begin
               next_strobe.reset_n = 1'b1;
               next_strobe.retx_n = 1'b1;
               next_cnt = CNT_W'(FLAG_CYC + 3);
               next_state = AFH_RT_HIGH;
            end
         end
         AFH_W_LOW: begin
            // word latches on the rising edge of the strobe
            if (cnt_done(cnt)) begin
               next_strobe.write_n = 1'b1;
               next_cnt = CNT_W'(FLAG_CYC + 3);
               next_state = AFH_W_HIGH;
            end
         end
         AFH_R_LOW: begin
            // data held stable until strobe rises; sample then
            if (cnt_done(cnt)) begin
               // q2 has held the driven bus for one edge by now
               next_cap = q2;
               next_cap_valid = 1'b1;
               next_strobe.read_n = 1'b1;
               next_strobe.oe_n = 1'b1;
               next_cnt = CNT_W'(FLAG_CYC + 3);
               next_state = AFH_R_HIGH;
            end
         end
         AFH_W_HIGH, AFH_R_HIGH, AFH_RT_HIGH: begin
            // wait out flag settle plus sync delay; pointers wrap
            // inside the device, occupancy never tracked here
            if (cnt_done(cnt))
               next_state = AFH_IDLE;
         end
         default: begin
            next_state = AFH_IDLE;
         end
      endcase
   end

   // sequencer registers; strobes rest high, so the device sees no falling edge
   always_ff @(posedge sys_clk) begin
      if (srst) begin
         state <= AFH_IDLE;
         cnt <= '0;
         strobe <= '{write_n: 1'b1, read_n: 1'b1, reset_n: 1'b1,
                     retx_n: 1'b1, oe_n: 1'b1};
         dev_data_in <= '0;
         cap <= '0;
         cap_valid <= 1'b0;
         wr_ready_r <= 1'b0;
      end else begin
         state <= next_state;
         cnt <= next_cnt;
         strobe <= next_strobe;
         dev_data_in <= next_dev_data_in;
         cap <= next_cap;
         cap_valid <= next_cap_valid;
         wr_ready_r <= next_wr_ready;
      end
   end

   // the grant is set only in idle and stays in idle for its cycle,
   // so the output comes straight from its flop
   assign wr_ready = wr_ready_r;

   // two-entry output buffer: a stalled reader loses no word
   afh_skid #(
      .WIDTH (DW)
   ) u_skid (
      .sys_clk   (sys_clk),
      .srst      (srst),
      .in_data   (cap),
      .in_valid  (cap_valid),
      .in_ready  (sk_in_ready),
      .out_data  (rd_data),
      .out_valid (rd_valid),
      .out_ready (rd_ready)
   );
endmodule : afh_host
`default_nettype wire

/* bench/afh_props.sv */
`timescale 1ns/1ns
`default_nettype none
// strobe discipline of the host, seen at its ports only
module afh_props
   import afh_pkg::*;
#(
   parameter int DW = DATA_W
) (
   input wire logic                 sys_clk,
   input wire logic                 srst,
   input wire logic                 wr_valid,
   input wire logic                 wr_ready,
   input wire logic [DW-1:0]        rd_data,
   input wire logic                 rd_valid,
   input wire logic                 rd_ready,
   input wire afh_pkg::afh_strobe_t strobe,
   input wire logic [DW-1:0]        dev_data_in
);
   default clocking @(posedge sys_clk); endclocking
   default disable iff (srst);
   wr_take_a: assert property ($fell(strobe.write_n) |->
      $past(wr_valid && wr_ready)) else $error("write without taken word");
   wr_short_a: assert property ($fell(strobe.write_n) |->
      ##[1:2] strobe.write_n) else $error("write strobe too long");
   wr_hold_a: assert property ($rose(strobe.write_n) |->
      $stable(dev_data_in)) else $error("data moved at write edge");
   rd_width_a: assert property ($fell(strobe.read_n) |->
      !strobe.read_n [*3] ##1 strobe.read_n) else $error("read width");
   one_op_a: assert property (strobe.write_n || strobe.read_n)
      else $error("read and write strobes low together");
   ready_idle_a: assert property (wr_ready |->
      strobe.write_n && strobe.read_n) else $error("grant while busy");
   rd_deliver_a: assert property ($rose(strobe.read_n) |->
      ##[0:2] rd_valid) else $error("read word not delivered");
   rd_keep_a: assert property (rd_valid && !rd_ready |=>
      rd_valid && $stable(rd_data)) else $error("stalled word lost");
   // main traffic kinds
   wr_c: cover property ($fell(strobe.write_n));
   rd_c: cover property ($fell(strobe.read_n));
   clr_c: cover property ($fell(strobe.reset_n));
   rt_c: cover property ($fell(strobe.retx_n));
endmodule : afh_props
bind afh_host afh_props #(.DW(DW)) props_i (.sys_clk, .srst, .wr_valid,
   .wr_ready, .rd_data, .rd_valid, .rd_ready, .strobe, .dev_data_in);
`default_nettype wire

/* bench/afh_dev.sv */
`timescale 1ns/1ns
`default_nettype none
// strobe-driven buffer device; flags change at once, so pulses can be 0 wide
module afh_dev
   import afh_pkg::*;
#(
   parameter int DEPTH = 4
) (
   input  wire afh_pkg::afh_strobe_t strobe,
   input  wire logic [DATA_W-1:0]    d,
   output logic                      full_flag_n,
   output logic                      empty_flag_n,
   output logic      [DATA_W-1:0]    q,
   output int                        bad
);
   logic [DATA_W-1:0]       mem [DEPTH];
   logic [DATA_W-1:0]       last = '0;
   int                      wp = 0, rp = 0, cnt = 0;
   logic                    act = 1'b0;
   logic                    wr_low = 1'b0;
   initial bad = 0;
   assign empty_flag_n = (cnt != 0);
   assign full_flag_n  = (cnt != DEPTH);
   // a rise counts only after a fall, so the reset step from X is no write
   always @(negedge strobe.write_n) wr_low = 1'b1;
   // word stored on the rising write edge; pointers wrap; a read that
   // freed space under a held write lets this edge refill the buffer
   always @(posedge strobe.write_n) begin
      if (wr_low) begin
         wr_low = 1'b0;
         if (cnt == DEPTH) bad++;
         else begin
            mem[wp] = d;
            wp = (wp + 1) % DEPTH;
            cnt++;
            if (!strobe.read_n) act = 1'b1;
         end
      end
   end
   // a read on empty is host misuse; the pointer is blocked
   always @(negedge strobe.read_n) begin
      if (cnt == 0) bad++;
      else act = 1'b1;
   end
   // pointer moves only when the read strobe rises
   always @(posedge strobe.read_n) begin
      if (act) begin
         last = mem[rp];
         rp = (rp + 1) % DEPTH;
         cnt--;
         act = 1'b0;
      end
   end
   always @(negedge strobe.reset_n) begin
      wp = 0;
      rp = 0;
      cnt = 0;
   end
   // retransmit assumes no wrap since the last clear
   always @(negedge strobe.retx_n) begin
      rp = 0;
      cnt = wp;
   end
   // released bus shows the inverse of the last word, never a stale copy
   assign q = (!strobe.read_n && !strobe.oe_n && act) ? mem[rp] : ~last;
endmodule : afh_dev
`default_nettype wire

/* bench/tb.sv */
`timescale 1ns/1ns
`default_nettype none
module tb;
   import afh_pkg::*;
   logic              sys_clk, srst, clear_req, retx_req, wr_valid, rd_ready;
   logic              wr_ready, rd_valid, full_flag_n, empty_flag_n;
   logic [DATA_W-1:0] wr_data, rd_data, dev_data_in, data_out_bus;
   logic [DATA_W-1:0] w [3];
   logic [DATA_W-1:0] exp_q [$];
   afh_strobe_t       strobe;
   int                err_total = 0, check_count = 0, cyc = 0, bad;
   logic              stall = 1'b1;
   afh_host uut (.sys_clk, .srst, .clear_req, .retx_req, .wr_data, .wr_valid,
      .wr_ready, .rd_data, .rd_valid, .rd_ready, .strobe, .dev_data_in,
      .full_flag_n, .empty_flag_n, .data_out_bus);
   afh_dev dev (.strobe, .d(dev_data_in), .full_flag_n, .empty_flag_n,
      .q(data_out_bus), .bad);
   initial begin
      sys_clk = 1'b0;
      forever #50 sys_clk = ~sys_clk;
   end
   task automatic check(input string nm, input logic [DATA_W-1:0] s, e);
      check_count++;
      if (s !== e) begin
         err_total++;
         $display("[ERR] %s expected %h seen %h", nm, e, s);
      end
   endtask : check
   task automatic tally_and_finish;
      if (err_total == 0 && check_count > 0) $display("All checks passed");
      else $display("Checks failed");
      $finish;
   endtask : tally_and_finish
   // hold the word until a taken edge, then note it
   task automatic put(input logic [DATA_W-1:0] v);
      logic ok;
      wr_data  <= v;
      wr_valid <= 1'b1;
      do begin
         @(negedge sys_clk);
         ok = wr_ready;
         @(posedge sys_clk);
      end while (!ok);
      exp_q.push_back(v);
   endtask : put
   // bounded wait for all noted words, then let the host go idle
   task automatic drain;
      repeat (3000) begin
         @(posedge sys_clk);
         if (exp_q.size() == 0) break;
      end
      repeat (20) @(posedge sys_clk);
      check("pending", DATA_W'(exp_q.size()), '0);
   endtask : drain
   // monitor: every delivered word against the oldest note; hang guard
   always @(posedge sys_clk) begin
      cyc <= cyc + 1;
      if (!srst && rd_valid && rd_ready) begin
         if (exp_q.size() == 0) check("rd_surplus", 9'h001, '0);
         else check("rd_data", rd_data, exp_q.pop_front());
      end
      if (cyc > 20000) begin
         err_total++;
         tally_and_finish();
      end
   end
   // reader stalls first so device and buffer both fill
   always @(posedge sys_clk) rd_ready <= stall ? 1'b0 : 1'($urandom);
   initial begin
      srst = 1'b1;
      {clear_req, retx_req, wr_valid} = '0;
      wr_data = '0;
      void'($urandom(54));
      repeat (12) @(posedge sys_clk);
      srst <= 1'b0;
      repeat (5) @(posedge sys_clk);
      for (int i = 0; i < 6; i++) put(DATA_W'($urandom));
      wr_valid <= 1'b0;
      repeat (100) @(posedge sys_clk);
      check("full_flag_n", 9'(full_flag_n), '0);
      stall = 1'b0;
      for (int i = 0; i < 7; i++) put(DATA_W'($urandom));
      wr_valid <= 1'b0;
      drain();
      // clear, refill from location zero, replay by retransmit
      clear_req <= 1'b1;
      @(posedge sys_clk);
      clear_req <= 1'b0;
      repeat (10) @(posedge sys_clk);
      for (int i = 0; i < 3; i++) begin
         w[i] = DATA_W'($urandom);
         put(w[i]);
      end
      wr_valid <= 1'b0;
      drain();
      retx_req <= 1'b1;
      @(posedge sys_clk);
      retx_req <= 1'b0;
      for (int i = 0; i < 3; i++) exp_q.push_back(w[i]);
      drain();
      check("misuse", 9'(bad), '0);
      tally_and_finish();
   end
endmodule : tb
`default_nettype wire
